//--- tb_top.sv
// testbench for the usb event interrupt controller
// assumes bus reset count shortened to 20 cycles
`timescale 1ns/1ps

module tb_top
  import usbeic_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [14:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] ev;
  logic        usb_se0, cpu_irq, usb_logic_reset, er;
  int          err_count, samples_checked, rst_pulses;

  usbeic_top #(.BUS_RESET_CYC(20)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sof_valid(ev[0]), .frame_timer_end(ev[1]), .ep_rx_out(ev[6:2]),
    .ep_rx_setup(ev[11:7]), .ep_tx_complete(ev[16:12]),
    .remote_wakeup(ev[17]), .resume_other_port(ev[18]),
    .global_suspend(ev[19]), .ext_irq_event(ev[23:20]),
    .usb_se0(usb_se0), .cpu_irq(cpu_irq), .usb_logic_reset(usb_logic_reset));

  usbeic_usb_model u_usb (.pclk(pclk), .ev(ev), .usb_se0(usb_se0));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) if (usb_logic_reset === 1'b1) rst_pulses++;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [12:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [12:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask

  task automatic irq_chk(input logic e);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    check({31'h0, cpu_irq}, {31'h0, e});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rd_chk(USBEIC_IDX_EVENT_ENABLE, 32'h0);
    rd_chk(USBEIC_IDX_EVENT_MASK, 32'h0);
    rd_chk(USBEIC_IDX_SR_ENABLE, 32'h0);
    rd_chk(USBEIC_IDX_SR_STATUS, 32'h0);
    apb(1'b1, USBEIC_IDX_EVENT_ENABLE, 32'hff);
    rd_chk(USBEIC_IDX_EVENT_ENABLE, 32'hdf);
    apb(1'b1, USBEIC_IDX_EVENT_MASK, 32'hff);
    rd_chk(USBEIC_IDX_EVENT_MASK, 32'hdf);
    pstrb <= 4'h0;
    apb(1'b1, USBEIC_IDX_EVENT_ENABLE, 32'h0);
    pstrb <= 4'hf;
    rd_chk(USBEIC_IDX_EVENT_ENABLE, 32'hdf);
    apb(1'b0, 13'h1ff0, 32'h0);
    check({31'h0, er}, 32'h1);
    $display("t_regs finished");
  endtask

  task automatic t_usb_events;
    logic [7:0] exp;
    apb(1'b1, USBEIC_IDX_EVENT_MASK, 32'h0);
    apb(1'b1, USBEIC_IDX_IRQ_ENABLE, 32'h3);
    for (int k = 0; k < 17; k++) begin
      exp = (k == 0) ? 8'h80 : (k == 1) ? 8'h40 : 8'h01 << ((k - 2) % 5);
      u_usb.pulse(24'h1 << k);
      irq_chk(1'b1);
      rd_chk(USBEIC_IDX_EVENT_STATUS, {24'h0, exp});
      rd_chk(USBEIC_IDX_IRQ_STATUS, 32'h1);
      apb(1'b1, USBEIC_IDX_EVENT_ACK, {24'h0, ~exp});
      rd_chk(USBEIC_IDX_EVENT_STATUS, {24'h0, exp});
      apb(1'b1, USBEIC_IDX_EVENT_ACK, {24'h0, exp});
      rd_chk(USBEIC_IDX_EVENT_STATUS, 32'h0);
      apb(1'b1, USBEIC_IDX_IRQ_CLEAR, 32'h3);
    end
    $display("t_usb_events finished");
  endtask

  task automatic t_usb_gate;
    apb(1'b1, USBEIC_IDX_EVENT_MASK, 32'h80);
    u_usb.pulse(24'h1);
    irq_chk(1'b0);
    rd_chk(USBEIC_IDX_EVENT_STATUS, 32'h80);
    apb(1'b1, USBEIC_IDX_EVENT_ACK, 32'h80);
    apb(1'b1, USBEIC_IDX_EVENT_MASK, 32'h0);
    apb(1'b1, USBEIC_IDX_EVENT_ENABLE, 32'h7f);
    u_usb.pulse(24'h1);
    irq_chk(1'b0);
    apb(1'b1, USBEIC_IDX_EVENT_ACK, 32'h80);
    $display("t_usb_gate finished");
  endtask

  task automatic t_sr_events;
    logic [7:0] exp;
    apb(1'b1, USBEIC_IDX_SR_ENABLE, 32'hf7);
    apb(1'b1, USBEIC_IDX_SR_VISIBLE, 32'hf7);
    for (int k = 17; k < 24; k++) begin
      exp = (k < 20) ? 8'h04 >> (k - 17) : 8'h10 << (k - 20);
      u_usb.pulse(24'h1 << k);
      irq_chk(1'b1);
      rd_chk(USBEIC_IDX_SR_STATUS, {24'h0, exp});
      rd_chk(USBEIC_IDX_IRQ_STATUS, 32'h2);
      apb(1'b1, USBEIC_IDX_SR_STATUS, {24'h0, ~exp & 8'hf7});
      rd_chk(USBEIC_IDX_SR_STATUS, 32'h0);
      apb(1'b1, USBEIC_IDX_IRQ_CLEAR, 32'h3);
    end
    check(32'(rst_pulses), 32'h0);
    apb(1'b1, USBEIC_IDX_SR_VISIBLE, 32'h0);
    u_usb.pulse(24'h80000);
    irq_chk(1'b0);
    rd_chk(USBEIC_IDX_SR_STATUS, 32'h1);
    apb(1'b1, USBEIC_IDX_SR_STATUS, 32'h0);
    $display("t_sr_events finished");
  endtask

  task automatic t_bus_reset;
    apb(1'b1, USBEIC_IDX_SR_VISIBLE, 32'h8);
    apb(1'b1, USBEIC_IDX_SR_ENABLE, 32'h0);
    u_usb.se0(40);
    rd_chk(USBEIC_IDX_SR_STATUS, 32'h0);
    check(32'(rst_pulses), 32'h0);
    apb(1'b1, USBEIC_IDX_SR_ENABLE, 32'h8);
    u_usb.se0(10);
    check(32'(rst_pulses), 32'h0);
    u_usb.se0(40);
    irq_chk(1'b1);
    check(32'(rst_pulses), 32'h1);
    rd_chk(USBEIC_IDX_SR_STATUS, 32'h8);
    apb(1'b1, USBEIC_IDX_SR_STATUS, 32'h0);
    apb(1'b1, USBEIC_IDX_IRQ_CLEAR, 32'h3);
    apb(1'b1, USBEIC_IDX_SR_VISIBLE, 32'h0);
    u_usb.se0(40);
    check(32'(rst_pulses), 32'h2);
    rd_chk(USBEIC_IDX_SR_STATUS, 32'h0);
    $display("t_bus_reset finished");
  endtask

  // ---------------------------------------------------------------
  // sequence and verdict
  // ---------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    results();
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 15'h0;
    pwdata  = 32'h0;
    pstrb   = 4'hf;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_usb_events();
    t_usb_gate();
    t_sr_events();
    t_bus_reset();
    results();
  end
endmodule // tb_top

//--- usbeic_pkg.sv
// package for the usb event interrupt controller: register map, field layout, timing counts
// assumes an apb slave on pclk at 100 mhz with 32-bit data
package usbeic_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [12:0] USBEIC_IDX_EVENT_ENABLE  = 13'h1ff3;
  localparam logic [12:0] USBEIC_IDX_EVENT_ACK     = 13'h1ff5;
  localparam logic [12:0] USBEIC_IDX_EVENT_MASK    = 13'h1ff6;
  localparam logic [12:0] USBEIC_IDX_EVENT_STATUS  = 13'h1ff7;
  localparam logic [12:0] USBEIC_IDX_SR_VISIBLE    = 13'h1ff8;
  localparam logic [12:0] USBEIC_IDX_SR_ENABLE     = 13'h1ff9;
  localparam logic [12:0] USBEIC_IDX_SR_STATUS     = 13'h1ffa;
  localparam logic [12:0] USBEIC_IDX_IRQ_STATUS    = 13'h1ffc;
  localparam logic [12:0] USBEIC_IDX_IRQ_ENABLE    = 13'h1ffd;
  localparam logic [12:0] USBEIC_IDX_IRQ_CLEAR     = 13'h1ffe;
  localparam int          USBEIC_ADDR_W            = 15;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  USBEIC_EVENT_VALID_BITS  = 8'hdf;
  localparam int          USBEIC_BIT_BUS_RESET     = 3;
  localparam int          USBEIC_BIT_FRAME_START   = 7;
  localparam int          USBEIC_BIT_FRAME_END     = 6;
  localparam logic [7:0]  USBEIC_REG_RESET         = 8'h00;
  localparam logic [1:0]  USBEIC_IRQ_RESET         = 2'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          USBEIC_CLK_MHZ           = 100;
  localparam int          USBEIC_BUS_RESET_MS      = 3;
  localparam int          USBEIC_BUS_RESET_CYC     = USBEIC_BUS_RESET_MS * 1000 * USBEIC_CLK_MHZ;
  localparam int          USBEIC_FRAME_END_LEAD    = 10;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] frame_start_sync;
    logic [7:0] ep_event_sync;
    logic [7:0] sr_event_sync;
    logic [1:0] se0_sync;
  } usbeic_sync_type;

  typedef struct packed {
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [USBEIC_ADDR_W-1:0] paddr;
    logic [31:0]             pwdata;
  } usbeic_apb_req_type;

  typedef struct packed {
    logic [7:0]  usb_enable;
    logic [7:0]  usb_mask;
    logic [7:0]  usb_status;
    logic [7:0]  sr_visible;
    logic [7:0]  sr_enable;
    logic [7:0]  sr_status;
    logic [1:0]  irq_status;
    logic [1:0]  irq_enable;
    logic [31:0] bus_reset_count;
    logic        se0_seen;
    logic        usb_logic_reset;
    logic        cpu_irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } usbeic_state_type;

endpackage

//--- usbeic_top.sv
// usb event interrupt controller: usb event and suspend/resume status, enable, mask, ack
// assumes event inputs are one-cycle pulses from logic on pclk; se0 line comes from a pin
`timescale 1ns/1ps

module usbeic_top
  import usbeic_pkg::*;
#(
  parameter int BUS_RESET_CYC = USBEIC_BUS_RESET_CYC
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [USBEIC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  // usb hub/function events, one-cycle pulses on pclk
  input  wire logic                     sof_valid,
  input  wire logic                     frame_timer_end,
  input  wire logic [4:0]               ep_rx_out,
  input  wire logic [4:0]               ep_rx_setup,
  input  wire logic [4:0]               ep_tx_complete,
  input  wire logic                     remote_wakeup,
  input  wire logic                     resume_other_port,
  input  wire logic                     global_suspend,
  // external interrupt pin events, bit 0 is pin a
  input  wire logic [3:0]               ext_irq_event,
  // usb line single-ended zero, from a pin
  input  wire logic                     usb_se0,
  // outputs
  output logic                          cpu_irq,
  output logic                          usb_logic_reset
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  usbeic_state_type st_reg;
  usbeic_state_type st_next;
  logic [1:0]       se0_sync_reg;

  // two-flop synchroniser on the se0 pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      se0_sync_reg <= 2'h0;
    end else begin
      se0_sync_reg <= {se0_sync_reg[0], usb_se0};
    end
  end

  // ---------------------------------------------------------------
  // decode and event gathering
  // ---------------------------------------------------------------
  logic [12:0] idx;
  logic        access;
  logic        wr;
  logic        rd;
  logic [7:0]  wdat;
  logic [7:0]  ep_set;
  logic [7:0]  usb_set;
  logic [7:0]  sr_set;
  logic        bus_reset_hit;
  logic        usb_pending;
  logic        sr_pending;

  assign idx    = paddr[USBEIC_ADDR_W-1:2];
  assign access = psel && penable;
  assign wr     = access && pwrite && pstrb[0];
  // reads decode in the setup cycle so prdata stands together with pready
  assign rd     = psel && !penable && !pwrite;
  assign wdat   = pwdata[7:0];

  // endpoint bits: ep0, ep1, ep2, hub ep0, ep3 at positions 0..4
  assign ep_set = {3'h0, ep_rx_out | ep_rx_setup | ep_tx_complete};
  assign usb_set = (ep_set
                   | ({7'h0, sof_valid} << USBEIC_BIT_FRAME_START)
                   | ({7'h0, frame_timer_end} << USBEIC_BIT_FRAME_END))
                   & USBEIC_EVENT_VALID_BITS;

  // fires once per se0 episode, in the cycle the count equals the limit minus one
  assign bus_reset_hit = st_reg.se0_seen && se0_sync_reg[1]
                         && (st_reg.bus_reset_count == 32'(BUS_RESET_CYC - 1));

  // pin events set bits 7..4 but never touch usb_logic_reset or wake logic
  assign sr_set = {ext_irq_event,
                   bus_reset_hit && st_reg.sr_enable[USBEIC_BIT_BUS_RESET]
                     && st_reg.sr_visible[USBEIC_BIT_BUS_RESET],
                   remote_wakeup,
                   resume_other_port,
                   global_suspend};

  assign usb_pending = |(st_reg.usb_status & st_reg.usb_enable & ~st_reg.usb_mask);
  assign sr_pending  = |(st_reg.sr_status & st_reg.sr_enable & st_reg.sr_visible);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next         = st_reg;
    st_next.pready  = 1'b0;
    st_next.pslverr = 1'b0;
    st_next.prdata  = 32'h0;
    st_next.usb_logic_reset = 1'b0;

    // se0 duration counter
    if (se0_sync_reg[1]) begin
      st_next.se0_seen = 1'b1;
      // saturates at the limit, one past the hit value, so a long se0 hits only once
      if (st_reg.bus_reset_count != 32'(BUS_RESET_CYC)) begin
        st_next.bus_reset_count = st_reg.bus_reset_count + 32'h1;
      end
    end else begin
      st_next.se0_seen        = 1'b0;
      st_next.bus_reset_count = 32'h0;
    end
    // usb-only reset pulse, once per se0 episode
    if (bus_reset_hit && st_reg.sr_enable[USBEIC_BIT_BUS_RESET]) begin
      st_next.usb_logic_reset = 1'b1;
    end

    // apb registers
    if (psel && !penable) begin
      st_next.pready = 1'b1;
      if (pwrite && idx != USBEIC_IDX_EVENT_ENABLE && idx != USBEIC_IDX_EVENT_MASK
          && idx != USBEIC_IDX_EVENT_ACK && idx != USBEIC_IDX_SR_VISIBLE
          && idx != USBEIC_IDX_SR_ENABLE && idx != USBEIC_IDX_SR_STATUS
          && idx != USBEIC_IDX_IRQ_ENABLE && idx != USBEIC_IDX_IRQ_CLEAR
          && idx != USBEIC_IDX_EVENT_STATUS && idx != USBEIC_IDX_IRQ_STATUS) begin
        st_next.pslverr = 1'b1;
      end
    end
    if (wr) begin
      if (idx == USBEIC_IDX_EVENT_ENABLE) begin
        st_next.usb_enable = wdat & USBEIC_EVENT_VALID_BITS;
      end else if (idx == USBEIC_IDX_EVENT_MASK) begin
        st_next.usb_mask = wdat & USBEIC_EVENT_VALID_BITS;
      end else if (idx == USBEIC_IDX_EVENT_ACK) begin
        st_next.usb_status = st_reg.usb_status & ~wdat;
      end else if (idx == USBEIC_IDX_SR_VISIBLE) begin
        st_next.sr_visible = wdat;
      end else if (idx == USBEIC_IDX_SR_ENABLE) begin
        st_next.sr_enable = wdat;
      end else if (idx == USBEIC_IDX_SR_STATUS) begin
        st_next.sr_status = st_reg.sr_status & wdat;
      end else if (idx == USBEIC_IDX_IRQ_ENABLE) begin
        st_next.irq_enable = wdat[1:0];
      end else if (idx == USBEIC_IDX_IRQ_CLEAR) begin
        st_next.irq_status = st_reg.irq_status & ~wdat[1:0];
      end
    end
    if (rd) begin
      if (idx == USBEIC_IDX_EVENT_ENABLE) begin
        st_next.prdata = {24'h0, st_reg.usb_enable};
      end else if (idx == USBEIC_IDX_EVENT_MASK) begin
        st_next.prdata = {24'h0, st_reg.usb_mask};
      end else if (idx == USBEIC_IDX_EVENT_STATUS) begin
        st_next.prdata = {24'h0, st_reg.usb_status};
      end else if (idx == USBEIC_IDX_SR_ENABLE) begin
        st_next.prdata = {24'h0, st_reg.sr_enable};
      end else if (idx == USBEIC_IDX_SR_STATUS) begin
        st_next.prdata = {24'h0, st_reg.sr_status};
      end else if (idx == USBEIC_IDX_IRQ_STATUS) begin
        st_next.prdata = {30'h0, st_reg.irq_status};
      end else if (idx == USBEIC_IDX_IRQ_ENABLE) begin
        st_next.prdata = {30'h0, st_reg.irq_enable};
      end else if (idx != USBEIC_IDX_EVENT_ACK && idx != USBEIC_IDX_SR_VISIBLE
                   && idx != USBEIC_IDX_IRQ_CLEAR) begin
        st_next.pslverr = 1'b1;
      end
    end

    // hardware sets win over software clears
    st_next.usb_status = st_next.usb_status | usb_set;
    st_next.sr_status  = st_next.sr_status | sr_set;
    st_next.irq_status = st_next.irq_status | {sr_pending, usb_pending};

    st_next.cpu_irq = |(st_next.irq_status & st_next.irq_enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready          = st_reg.pready;
  assign prdata          = st_reg.prdata;
  assign pslverr         = st_reg.pslverr;
  assign cpu_irq         = st_reg.cpu_irq;
  assign usb_logic_reset = st_reg.usb_logic_reset;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_ack_write(int b);
    wr && idx == USBEIC_IDX_EVENT_ACK && wdat[b] && !usb_set[b];
  endsequence

  property p_ack_clears;
    @(posedge pclk) disable iff (!presetn)
      s_ack_write(0) |=> !st_reg.usb_status[0];
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack write did not clear status");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      !st_reg.usb_enable[5] && !st_reg.usb_mask[5] && !st_reg.usb_status[5];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit 5 set");

  property p_sof_sets;
    @(posedge pclk) disable iff (!presetn)
      sof_valid |=> st_reg.usb_status[USBEIC_BIT_FRAME_START];
  endproperty
  a_sof_sets: assert property (p_sof_sets) else $error("frame start flag not set");

  property p_ext_sets;
    @(posedge pclk) disable iff (!presetn)
      ext_irq_event[3] |=> st_reg.sr_status[7];
  endproperty
  a_ext_sets: assert property (p_ext_sets) else $error("pin d flag not set");

  property p_sr_clear_zero;
    @(posedge pclk) disable iff (!presetn)
      wr && idx == USBEIC_IDX_SR_STATUS && !wdat[0] && !global_suspend |=> !st_reg.sr_status[0];
  endproperty
  a_sr_clear_zero: assert property (p_sr_clear_zero) else $error("zero write did not clear");

  property p_masked_usb;
    @(posedge pclk) disable iff (!presetn)
      (st_reg.usb_mask == 8'hdf) && (st_reg.sr_enable == 8'h00) && (st_reg.irq_status == 2'h0)
        |=> !st_reg.irq_status[0];
  endproperty
  a_masked_usb: assert property (p_masked_usb) else $error("masked usb event pending");

  property p_usb_irq;
    @(posedge pclk) disable iff (!presetn)
      usb_pending && st_reg.irq_enable[0] |=> ##1 cpu_irq;
  endproperty
  a_usb_irq: assert property (p_usb_irq) else $error("usb event did not interrupt");

  property p_sr_irq;
    @(posedge pclk) disable iff (!presetn)
      sr_pending && st_reg.irq_enable[1] |=> ##1 cpu_irq;
  endproperty
  a_sr_irq: assert property (p_sr_irq) else $error("suspend event did not interrupt");

  property p_bus_gate;
    @(posedge pclk) disable iff (!presetn)
      bus_reset_hit && !st_reg.sr_visible[USBEIC_BIT_BUS_RESET] && !st_reg.sr_status[3]
        && !(wr && idx == USBEIC_IDX_SR_STATUS) |=> !st_reg.sr_status[3];
  endproperty
  a_bus_gate: assert property (p_bus_gate) else $error("bus reset flag set while hidden");

  property p_se0_only_reset;
    @(posedge pclk) disable iff (!presetn)
      usb_logic_reset |-> $past(se0_sync_reg[1]);
  endproperty
  a_se0_only_reset: assert property (p_se0_only_reset) else $error("usb reset without se0");

  sequence s_setup_read(logic [12:0] a);
    psel && !penable && !pwrite && idx == a;
  endsequence

  sequence s_sof_enabled;
    sof_valid && st_reg.usb_enable[USBEIC_BIT_FRAME_START]
      && !st_reg.usb_mask[USBEIC_BIT_FRAME_START] && st_reg.irq_enable[0];
  endsequence

  property p_frame_end_sets;
    @(posedge pclk) disable iff (!presetn)
      frame_timer_end |=> st_reg.usb_status[USBEIC_BIT_FRAME_END];
  endproperty
  a_frame_end_sets: assert property (p_frame_end_sets) else $error("frame end flag not set");

  property p_ep_out_sets;
    @(posedge pclk) disable iff (!presetn)
      ep_rx_out[0] |=> st_reg.usb_status[0];
  endproperty
  a_ep_out_sets: assert property (p_ep_out_sets) else $error("endpoint out flag not set");

  property p_ep_tx_sets;
    @(posedge pclk) disable iff (!presetn)
      ep_tx_complete[3] |=> st_reg.usb_status[3];
  endproperty
  a_ep_tx_sets: assert property (p_ep_tx_sets) else $error("hub endpoint flag not set");

  property p_ext_a_sets;
    @(posedge pclk) disable iff (!presetn)
      ext_irq_event[0] |=> st_reg.sr_status[4];
  endproperty
  a_ext_a_sets: assert property (p_ext_a_sets) else $error("pin a flag not set");

  property p_wakeup_sets;
    @(posedge pclk) disable iff (!presetn)
      remote_wakeup |=> st_reg.sr_status[2];
  endproperty
  a_wakeup_sets: assert property (p_wakeup_sets) else $error("remote wakeup flag not set");

  property p_resume_sets;
    @(posedge pclk) disable iff (!presetn)
      resume_other_port |=> st_reg.sr_status[1];
  endproperty
  a_resume_sets: assert property (p_resume_sets) else $error("resume flag not set");

  property p_suspend_sets;
    @(posedge pclk) disable iff (!presetn)
      global_suspend |=> st_reg.sr_status[0];
  endproperty
  a_suspend_sets: assert property (p_suspend_sets) else $error("global suspend flag not set");

  property p_bus_sets;
    @(posedge pclk) disable iff (!presetn)
      bus_reset_hit && st_reg.sr_enable[USBEIC_BIT_BUS_RESET]
        && st_reg.sr_visible[USBEIC_BIT_BUS_RESET] |=> st_reg.sr_status[3];
  endproperty
  a_bus_sets: assert property (p_bus_sets) else $error("bus reset flag not set");

  property p_reset_enabled;
    @(posedge pclk) disable iff (!presetn)
      usb_logic_reset |-> $past(st_reg.sr_enable[USBEIC_BIT_BUS_RESET]);
  endproperty
  a_reset_enabled: assert property (p_reset_enabled) else $error("usb reset while not enabled");

  property p_reset_pulse;
    @(posedge pclk) disable iff (!presetn)
      usb_logic_reset |=> !usb_logic_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("usb reset longer than one cycle");

  property p_ext_no_reset;
    @(posedge pclk) disable iff (!presetn)
      (ext_irq_event != 4'h0) && !bus_reset_hit |=> !usb_logic_reset;
  endproperty
  a_ext_no_reset: assert property (p_ext_no_reset) else $error("pin event reset usb logic");

  property p_ack_keeps;
    @(posedge pclk) disable iff (!presetn)
      wr && idx == USBEIC_IDX_EVENT_ACK && !wdat[7] && st_reg.usb_status[7] |=> st_reg.usb_status[7];
  endproperty
  a_ack_keeps: assert property (p_ack_keeps) else $error("zero ack bit cleared a flag");

  property p_sr_hidden;
    @(posedge pclk) disable iff (!presetn)
      (st_reg.sr_visible == 8'h00) && !st_reg.irq_status[1] |=> !st_reg.irq_status[1];
  endproperty
  a_sr_hidden: assert property (p_sr_hidden) else $error("hidden suspend event pending");

  property p_mask_read;
    @(posedge pclk) disable iff (!presetn)
      s_setup_read(USBEIC_IDX_EVENT_MASK) |=> pready && !prdata[5];
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read bad");

  property p_sof_irq;
    @(posedge pclk) disable iff (!presetn)
      s_sof_enabled |=> ##1 cpu_irq;
  endproperty
  a_sof_irq: assert property (p_sof_irq) else $error("frame start did not interrupt");

  property p_cpu_irq_source;
    @(posedge pclk) disable iff (!presetn)
      cpu_irq |-> (st_reg.irq_status & st_reg.irq_enable) != 2'h0;
  endproperty
  a_cpu_irq_source: assert property (p_cpu_irq_source) else $error("interrupt without source");

endmodule // usbeic_top

//--- usbeic_usb_model.sv
// usb hub/function hardware model: one-cycle event pulses and the se0 line
// assumes the controller samples every event on the rising edge of pclk
`timescale 1ns/1ps

module usbeic_usb_model (
  // clock
  input  wire logic pclk,
  // events and line state
  output logic [23:0] ev,
  output logic        usb_se0
);
  initial begin
    ev      = 24'h0;
    usb_se0 = 1'b0;
  end

  // one-cycle pulse, no frame-end lead is applied here
  task automatic pulse(input logic [23:0] v);
    @(posedge pclk) ev <= v;
    @(posedge pclk) ev <= 24'h0;
  endtask

  // single-ended zero held for n cycles
  task automatic se0(input int n);
    @(posedge pclk) usb_se0 <= 1'b1;
    repeat (n) @(posedge pclk);
    usb_se0 <= 1'b0;
  endtask
endmodule // usbeic_usb_model
